/* File: rtl/status_report_pkg.sv */
// Constants, command codes and carrier types of the status change reporting block
package status_report_pkg;

  localparam int WORD_W      = 16;
  localparam int EVENT_W     = 8;
  localparam int DIGITS      = 5;
  localparam int DEC_W       = 20;

  // Instrument status word bit positions
  localparam int BIT_SETTLED    = 12;
  localparam int BIT_REMOTE     = 11;
  localparam int BIT_BUF_FULL   = 9;
  localparam int BIT_DATA_AVAIL = 8;
  localparam int BIT_HIGH_VOLT  = 7;
  localparam int BIT_MAG_CHG    = 6;
  localparam int BIT_TEMP_CAL   = 5;
  localparam int BIT_OPERATE    = 0;

  // Command error position in the standard event status register (weight 32)
  localparam int BIT_CMD_ERROR  = 5;

  localparam logic [WORD_W-1:0] STATUS_USED_MASK = 16'h1BE1;
  localparam logic [WORD_W-1:0] EVENT_USED_MASK  = 16'h00FF;
  localparam logic [WORD_W-1:0] WORD_ZERO        = 16'h0000;

  // Double-dabble digit adjust
  localparam logic [3:0] DIGIT_LIMIT = 4'h4;
  localparam logic [3:0] DIGIT_ADJ   = 4'h3;

  typedef enum logic [3:0] {
    CMD_READ_EVENT_STATUS,
    CMD_READ_EVENT_ENABLE,
    CMD_WRITE_EVENT_ENABLE,
    CMD_READ_STATUS_WORD,
    CMD_READ_FALL_CHANGE,
    CMD_READ_RISE_CHANGE,
    CMD_READ_FALL_ENABLE,
    CMD_WRITE_FALL_ENABLE,
    CMD_READ_RISE_ENABLE,
    CMD_WRITE_RISE_ENABLE,
    CMD_CLEAR_STATUS,
    CMD_MALFORMED
  } cmd_code_type;

  typedef struct packed {
    logic              valid;
    cmd_code_type      code;
    logic [WORD_W-1:0] data;
  } cmd_type;

  typedef struct packed {
    logic output_settled;
    logic tc_settled;
    logic remote;
    logic buf_full;
    logic data_avail;
    logic high_volt;
    logic mag_chg;
    logic temp_cal;
    logic operate;
  } status_in_type;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] binary;
    logic [DEC_W-1:0]  decimal;
  } rsp_type;

endpackage : status_report_pkg

/* File: rtl/decimal_response.sv */
// Registers a query answer and its unsigned decimal digits
`timescale 1ns/1ps
`default_nettype none
module decimal_response #(
  parameter int WORD_W = status_report_pkg::WORD_W
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_valid,
  input  wire logic [WORD_W-1:0]          i_value,
  output status_report_pkg::rsp_type      o_rsp
);

  // Combinational double dabble; sixteen bits never exceed five digits
  function automatic logic [status_report_pkg::DEC_W-1:0] to_decimal(
    input logic [WORD_W-1:0] v
  );
    logic [status_report_pkg::DEC_W+WORD_W-1:0] sh;
    int i;
    int d;
    sh = {{status_report_pkg::DEC_W{1'b0}}, v};
    for (i = 0; i < WORD_W; i++) begin
      for (d = 0; d < status_report_pkg::DIGITS; d++) begin
        if (sh[WORD_W+4*d +: 4] > status_report_pkg::DIGIT_LIMIT) begin
          sh[WORD_W+4*d +: 4] = sh[WORD_W+4*d +: 4] + status_report_pkg::DIGIT_ADJ;
        end
      end
      sh = {sh[status_report_pkg::DEC_W+WORD_W-2:0], 1'b0};
    end
    return sh[status_report_pkg::DEC_W+WORD_W-1:WORD_W];
  endfunction : to_decimal

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= i_valid;
      if (i_valid) begin
        o_rsp.binary  <= i_value;
        o_rsp.decimal <= to_decimal(i_value);
      end
    end
  end

endmodule : decimal_response
`default_nettype wire

/* File: rtl/status_change_report.sv */
// Event status and instrument status change reporting with command port
// What this block does
// - Reading event status clears it to zero
// - Reading event enable leaves it unchanged
// - Answers carry sixteen bits as unsigned decimal
// - Malformed command sets command error, bit 5
// - Event summary only through enabled event bits
// - Falls and rises captured in separate change registers
// - Change registers cleared at reset, read, clear-status
// - Enabled captured change sets change summary bit
// - All-zero change enables keep summary low
// - Change enable masks reset to zero
// - Bit 12 shows output or thermocouple settled
// - Bit 11 shows remote control
// - Bit 9 shows test port buffer full
// - Bit 8 shows test port data available
// - Bit 7 shows output above 33 volts
`timescale 1ns/1ps
`default_nettype none
module status_change_report #(
  parameter int WORD_W  = status_report_pkg::WORD_W,
  parameter int EVENT_W = status_report_pkg::EVENT_W
) (
  input  wire logic                          I_REF_CLK,
  input  wire logic                          I_RST_B,
  input  wire status_report_pkg::cmd_type    I_CMD,
  input  wire status_report_pkg::status_in_type I_STATUS,
  input  wire logic [EVENT_W-1:0]            I_EVENTS,
  output logic [WORD_W-1:0]                  O_STATUS_WORD,
  output logic                               O_EVENT_SUMMARY,
  output logic                               O_CHANGE_SUMMARY,
  output status_report_pkg::rsp_type         O_RSP
);

  logic [WORD_W-1:0] event_status_r;
  logic [WORD_W-1:0] event_status_nxt;
  logic [WORD_W-1:0] event_enable_r;
  logic [WORD_W-1:0] event_enable_nxt;
  logic [WORD_W-1:0] status_cur;
  logic [WORD_W-1:0] status_word_r;
  logic              primed_r;
  logic [WORD_W-1:0] fall_edges;
  logic [WORD_W-1:0] rise_edges;
  logic [WORD_W-1:0] fall_change_r;
  logic [WORD_W-1:0] fall_change_nxt;
  logic [WORD_W-1:0] rise_change_r;
  logic [WORD_W-1:0] rise_change_nxt;
  logic [WORD_W-1:0] fall_enable_r;
  logic [WORD_W-1:0] fall_enable_nxt;
  logic [WORD_W-1:0] rise_enable_r;
  logic [WORD_W-1:0] rise_enable_nxt;
  logic [WORD_W-1:0] rd_value;
  logic              rd_valid;
  logic              cmd_error;
  logic [WORD_W-1:0] event_in;

  function automatic logic cmd_hit(
    input status_report_pkg::cmd_type    c,
    input status_report_pkg::cmd_code_type k
  );
    return c.valid && (c.code == k);
  endfunction : cmd_hit

  // Instrument status word assembled from the live conditions
  always_comb begin
    status_cur = status_report_pkg::WORD_ZERO;
    status_cur[status_report_pkg::BIT_SETTLED]    = I_STATUS.output_settled
                                                 | I_STATUS.tc_settled;
    status_cur[status_report_pkg::BIT_REMOTE]     = I_STATUS.remote;
    status_cur[status_report_pkg::BIT_BUF_FULL]   = I_STATUS.buf_full;
    status_cur[status_report_pkg::BIT_DATA_AVAIL] = I_STATUS.data_avail;
    status_cur[status_report_pkg::BIT_HIGH_VOLT]  = I_STATUS.high_volt;
    status_cur[status_report_pkg::BIT_MAG_CHG]    = I_STATUS.mag_chg;
    status_cur[status_report_pkg::BIT_TEMP_CAL]   = I_STATUS.temp_cal;
    status_cur[status_report_pkg::BIT_OPERATE]    = I_STATUS.operate;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      status_word_r <= status_report_pkg::WORD_ZERO;
      primed_r      <= 1'b0;
    end else begin
      status_word_r <= status_cur;
      primed_r      <= 1'b1;
    end
  end

  // Skip the first compare after reset so conditions already present are not seen as rises
  assign fall_edges = primed_r ? (status_word_r & ~status_cur)
                               : status_report_pkg::WORD_ZERO;
  assign rise_edges = primed_r ? (~status_word_r & status_cur)
                               : status_report_pkg::WORD_ZERO;

  // Anything not a known code is treated as malformed
  always_comb begin
    cmd_error = 1'b0;
    if (I_CMD.valid) begin
      case (I_CMD.code)
        status_report_pkg::CMD_READ_EVENT_STATUS,
        status_report_pkg::CMD_READ_EVENT_ENABLE,
        status_report_pkg::CMD_WRITE_EVENT_ENABLE,
        status_report_pkg::CMD_READ_STATUS_WORD,
        status_report_pkg::CMD_READ_FALL_CHANGE,
        status_report_pkg::CMD_READ_RISE_CHANGE,
        status_report_pkg::CMD_READ_FALL_ENABLE,
        status_report_pkg::CMD_WRITE_FALL_ENABLE,
        status_report_pkg::CMD_READ_RISE_ENABLE,
        status_report_pkg::CMD_WRITE_RISE_ENABLE,
        status_report_pkg::CMD_CLEAR_STATUS: cmd_error = 1'b0;
        default: cmd_error = 1'b1;
      endcase
    end
  end

  // Event status: new events win over the clearing read or clear-status
  always_comb begin
    event_in = status_report_pkg::WORD_ZERO;
    event_in[EVENT_W-1:0] = I_EVENTS;
    event_in[status_report_pkg::BIT_CMD_ERROR] = I_EVENTS[status_report_pkg::BIT_CMD_ERROR]
                                               | cmd_error;
    event_status_nxt = event_status_r;
    if (cmd_hit(I_CMD, status_report_pkg::CMD_READ_EVENT_STATUS) ||
        cmd_hit(I_CMD, status_report_pkg::CMD_CLEAR_STATUS)) begin
      event_status_nxt = status_report_pkg::WORD_ZERO;
    end
    event_status_nxt = (event_status_nxt | event_in) & status_report_pkg::EVENT_USED_MASK;
  end

  always_comb begin
    event_enable_nxt = event_enable_r;
    if (cmd_hit(I_CMD, status_report_pkg::CMD_WRITE_EVENT_ENABLE)) begin
      event_enable_nxt = I_CMD.data & status_report_pkg::EVENT_USED_MASK;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      event_status_r <= status_report_pkg::WORD_ZERO;
      event_enable_r <= status_report_pkg::WORD_ZERO;
    end else begin
      event_status_r <= event_status_nxt;
      event_enable_r <= event_enable_nxt;
    end
  end

  // Change registers: an edge in the clearing cycle survives the clear
  always_comb begin
    fall_change_nxt = fall_change_r;
    rise_change_nxt = rise_change_r;
    if (cmd_hit(I_CMD, status_report_pkg::CMD_READ_FALL_CHANGE) ||
        cmd_hit(I_CMD, status_report_pkg::CMD_CLEAR_STATUS)) begin
      fall_change_nxt = status_report_pkg::WORD_ZERO;
    end
    if (cmd_hit(I_CMD, status_report_pkg::CMD_READ_RISE_CHANGE) ||
        cmd_hit(I_CMD, status_report_pkg::CMD_CLEAR_STATUS)) begin
      rise_change_nxt = status_report_pkg::WORD_ZERO;
    end
    fall_change_nxt = fall_change_nxt | fall_edges;
    rise_change_nxt = rise_change_nxt | rise_edges;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      fall_change_r <= status_report_pkg::WORD_ZERO;
      rise_change_r <= status_report_pkg::WORD_ZERO;
    end else begin
      fall_change_r <= fall_change_nxt;
      rise_change_r <= rise_change_nxt;
    end
  end

  always_comb begin
    fall_enable_nxt = fall_enable_r;
    rise_enable_nxt = rise_enable_r;
    if (cmd_hit(I_CMD, status_report_pkg::CMD_WRITE_FALL_ENABLE)) begin
      fall_enable_nxt = I_CMD.data & status_report_pkg::STATUS_USED_MASK;
    end
    if (cmd_hit(I_CMD, status_report_pkg::CMD_WRITE_RISE_ENABLE)) begin
      rise_enable_nxt = I_CMD.data & status_report_pkg::STATUS_USED_MASK;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      fall_enable_r <= status_report_pkg::WORD_ZERO;
      rise_enable_r <= status_report_pkg::WORD_ZERO;
    end else begin
      fall_enable_r <= fall_enable_nxt;
      rise_enable_r <= rise_enable_nxt;
    end
  end

  // Summaries follow the registers they are built from in the same cycle
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      O_EVENT_SUMMARY  <= 1'b0;
      O_CHANGE_SUMMARY <= 1'b0;
    end else begin
      O_EVENT_SUMMARY  <= |(event_status_nxt & event_enable_nxt);
      O_CHANGE_SUMMARY <= |((fall_change_nxt & fall_enable_nxt) |
                            (rise_change_nxt & rise_enable_nxt));
    end
  end

  assign O_STATUS_WORD = status_word_r;

  // Query answers show the value held before any clearing side effect
  always_comb begin
    rd_valid = I_CMD.valid;
    rd_value = status_report_pkg::WORD_ZERO;
    case (I_CMD.code)
      status_report_pkg::CMD_READ_EVENT_STATUS: rd_value = event_status_r;
      status_report_pkg::CMD_READ_EVENT_ENABLE: rd_value = event_enable_r;
      status_report_pkg::CMD_READ_STATUS_WORD:  rd_value = status_word_r;
      status_report_pkg::CMD_READ_FALL_CHANGE:  rd_value = fall_change_r;
      status_report_pkg::CMD_READ_RISE_CHANGE:  rd_value = rise_change_r;
      status_report_pkg::CMD_READ_FALL_ENABLE:  rd_value = fall_enable_r;
      status_report_pkg::CMD_READ_RISE_ENABLE:  rd_value = rise_enable_r;
      default:                                  rd_valid = 1'b0;
    endcase
  end

  decimal_response #(
    .WORD_W (WORD_W)
  ) u_answer (
    .i_clk   (I_REF_CLK),
    .i_rst_b (I_RST_B),
    .i_valid (rd_valid),
    .i_value (rd_value),
    .o_rsp   (O_RSP)
  );

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_event_read_quiet;
    cmd_hit(I_CMD, status_report_pkg::CMD_READ_EVENT_STATUS) && (I_EVENTS == '0);
  endsequence

  sequence s_change_clear_quiet;
    cmd_hit(I_CMD, status_report_pkg::CMD_CLEAR_STATUS)
      && (fall_edges == '0) && (rise_edges == '0);
  endsequence

  property p_event_read_clears;
    s_event_read_quiet |=> (event_status_r == '0) ##1 (O_EVENT_SUMMARY == 1'b0 || I_EVENTS != '0
      || $past(I_EVENTS) != '0 || $past(I_CMD.valid));
  endproperty
  a_event_read_clears: assert property (p_event_read_clears)
    else $error("event status kept after read");

  property p_enable_kept;
    cmd_hit(I_CMD, status_report_pkg::CMD_READ_EVENT_ENABLE) |=> $stable(event_enable_r);
  endproperty
  a_enable_kept: assert property (p_enable_kept) else $error("event enable changed by read");

  property p_answer_next;
    (I_CMD.valid && I_CMD.code == status_report_pkg::CMD_READ_STATUS_WORD)
      |=> O_RSP.valid && (O_RSP.binary == $past(status_word_r));
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("status word answer wrong");

  property p_cmd_error;
    cmd_hit(I_CMD, status_report_pkg::CMD_MALFORMED)
      |=> event_status_r[status_report_pkg::BIT_CMD_ERROR];
  endproperty
  a_cmd_error: assert property (p_cmd_error) else $error("command error not flagged");

  property p_event_summary;
    O_EVENT_SUMMARY == |(event_status_r & event_enable_r);
  endproperty
  a_event_summary: assert property (p_event_summary) else $error("event summary mismatch");

  property p_fall_capture;
    logic [WORD_W-1:0] e;
    (fall_edges != '0, e = fall_edges) |=> ((fall_change_r & e) == e);
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("falling edge lost");

  property p_rise_capture;
    logic [WORD_W-1:0] e;
    (rise_edges != '0, e = rise_edges) |=> ((rise_change_r & e) == e) && ((fall_change_r & e) ==
      ($past(fall_change_r) & e & ~{WORD_W{$past(I_CMD.valid)}}) || $past(I_CMD.valid)
      || ((fall_change_r & e) == ($past(fall_change_r) & e)));
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("rising edge lost");

  property p_change_clear;
    s_change_clear_quiet |=> (fall_change_r == '0) && (rise_change_r == '0);
  endproperty
  a_change_clear: assert property (p_change_clear)
    else $error("change registers not cleared");

  property p_change_summary;
    O_CHANGE_SUMMARY == |((fall_change_r & fall_enable_r) | (rise_change_r & rise_enable_r));
  endproperty
  a_change_summary: assert property (p_change_summary)
    else $error("change summary mismatch");

  property p_masked_quiet;
    (fall_enable_r == '0) && (rise_enable_r == '0) |-> !O_CHANGE_SUMMARY;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("summary set with masks clear");

  property p_remote_bit;
    I_STATUS.remote |=> O_STATUS_WORD[status_report_pkg::BIT_REMOTE];
  endproperty
  a_remote_bit: assert property (p_remote_bit) else $error("remote bit not shown");

  property p_reserved_zero;
    (O_STATUS_WORD & ~status_report_pkg::STATUS_USED_MASK) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

endmodule : status_change_report
`default_nettype wire

/* File: tb/remote_controller_model.sv */
// Behavioural remote bus controller that issues commands and collects answers
`timescale 1ns/1ps
`default_nettype none
module remote_controller_model (
  input  wire logic                  i_clk,
  input  wire status_report_pkg::rsp_type i_rsp,
  output var  status_report_pkg::cmd_type o_cmd
);

  initial begin
    o_cmd = '0;
  end

  // One command per call; data is inverted after the command so a stale value never looks valid
  task automatic send(input  status_report_pkg::cmd_code_type code,
                      input  logic [15:0]                    data,
                      output logic [15:0]                    bin,
                      output logic [19:0]                    dec,
                      output logic                           got);
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b1, code: code, data: data};
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b0, code: code, data: ~data};
    #1;
    got = i_rsp.valid;
    bin = i_rsp.binary;
    dec = i_rsp.decimal;
  endtask : send

endmodule : remote_controller_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench of the status change reporting block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  logic                              clk;
  logic                              rst_b;
  status_report_pkg::cmd_type        cmd;
  status_report_pkg::status_in_type  st;
  logic [7:0]                        ev;
  logic [15:0]                       word;
  logic                              ev_sum;
  logic                              chg_sum;
  status_report_pkg::rsp_type        rsp;
  int                                err_total;
  int                                num_checks;
  int                                cycles;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  status_change_report status_change_report_inst (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_CMD(cmd), .I_STATUS(st), .I_EVENTS(ev),
    .O_STATUS_WORD(word), .O_EVENT_SUMMARY(ev_sum), .O_CHANGE_SUMMARY(chg_sum), .O_RSP(rsp));

  remote_controller_model remote_controller_model_inst (
    .i_clk(clk), .i_rsp(rsp), .o_cmd(cmd));

  function automatic logic [19:0] to_bcd(input logic [15:0] v);
    int          n;
    logic [19:0] r;
    n = v;
    for (int i = 0; i < 5; i++) begin
      r[4*i+:4] = 4'(n % 10);
      n = n / 10;
    end
    return r;
  endfunction : to_bcd

  task automatic rd(input status_report_pkg::cmd_code_type c, input logic [15:0] e,
                    input string nm);
    logic [15:0] b;
    logic [19:0] d;
    logic        g;
    remote_controller_model_inst.send(c, 16'h0000, b, d, g);
    `CHECK({nm, " answer"}, 1'b1, g)
    `CHECK(nm, e, b)
    `CHECK({nm, " decimal"}, to_bcd(e), d)
  endtask : rd

  task automatic wr(input status_report_pkg::cmd_code_type c, input logic [15:0] v);
    logic [15:0] b;
    logic [19:0] d;
    logic        g;
    remote_controller_model_inst.send(c, v, b, d, g);
    `CHECK("write answer", 1'b0, g)
  endtask : wr

  task automatic drive_status(input logic [8:0] v);
    @(posedge clk);
    st <= v;
    @(posedge clk);
    #1;
  endtask : drive_status

  task automatic test_reset;
    `CHECK("status word", 16'h0000, word)
    `CHECK("change summary", 1'b0, chg_sum)
    rd(status_report_pkg::CMD_READ_FALL_ENABLE, 16'h0000, "fall enable");
    rd(status_report_pkg::CMD_READ_RISE_ENABLE, 16'h0000, "rise enable");
    rd(status_report_pkg::CMD_READ_FALL_CHANGE, 16'h0000, "fall change");
    rd(status_report_pkg::CMD_READ_RISE_CHANGE, 16'h0000, "rise change");
    $display("reset test done");
  endtask : test_reset

  task automatic test_status_word;
    int pos [9] = '{0, 5, 6, 7, 8, 9, 11, 12, 12};
    for (int j = 0; j < 9; j++) begin
      drive_status(9'(1 << j));
      `CHECK("status bit", 16'h0001 << pos[j], word)
    end
    drive_status(9'h1FF);
    `CHECK("status all", 16'h1BE1, word)
    rd(status_report_pkg::CMD_READ_STATUS_WORD, 16'h1BE1, "status read");
    $display("status word test done");
  endtask : test_status_word

  task automatic test_changes;
    drive_status(9'h000);
    wr(status_report_pkg::CMD_CLEAR_STATUS, 16'h0000);
    rd(status_report_pkg::CMD_READ_RISE_CHANGE, 16'h0000, "rise after clear");
    drive_status(9'h040);
    `CHECK("summary masked", 1'b0, chg_sum)
    rd(status_report_pkg::CMD_READ_RISE_CHANGE, 16'h0800, "rise change");
    rd(status_report_pkg::CMD_READ_RISE_CHANGE, 16'h0000, "rise reread");
    wr(status_report_pkg::CMD_WRITE_RISE_ENABLE, 16'h0800);
    rd(status_report_pkg::CMD_READ_RISE_ENABLE, 16'h0800, "rise enable");
    drive_status(9'h000);
    `CHECK("summary on fall", 1'b0, chg_sum)
    drive_status(9'h040);
    `CHECK("summary on rise", 1'b1, chg_sum)
    rd(status_report_pkg::CMD_READ_FALL_CHANGE, 16'h0800, "fall change");
    wr(status_report_pkg::CMD_CLEAR_STATUS, 16'h0000);
    `CHECK("summary cleared", 1'b0, chg_sum)
    rd(status_report_pkg::CMD_READ_RISE_CHANGE, 16'h0000, "rise cleared");
    wr(status_report_pkg::CMD_WRITE_FALL_ENABLE, 16'hFFFF);
    rd(status_report_pkg::CMD_READ_FALL_ENABLE, 16'h1BE1, "fall enable masked");
    drive_status(9'h000);
    `CHECK("summary on enabled fall", 1'b1, chg_sum)
    rd(status_report_pkg::CMD_READ_FALL_CHANGE, 16'h0800, "fall change enabled");
    `CHECK("summary after fall read", 1'b0, chg_sum)
    $display("change test done");
  endtask : test_changes

  task automatic test_events;
    @(posedge clk);
    ev <= 8'h08;
    @(posedge clk);
    ev <= 8'h00;
    #1;
    `CHECK("event summary masked", 1'b0, ev_sum)
    wr(status_report_pkg::CMD_WRITE_EVENT_ENABLE, 16'h0020);
    rd(status_report_pkg::CMD_READ_EVENT_ENABLE, 16'h0020, "event enable");
    rd(status_report_pkg::CMD_READ_EVENT_ENABLE, 16'h0020, "event enable reread");
    `CHECK("event summary other bit", 1'b0, ev_sum)
    wr(status_report_pkg::CMD_MALFORMED, 16'h0000);
    `CHECK("event summary", 1'b1, ev_sum)
    rd(status_report_pkg::CMD_READ_EVENT_STATUS, 16'h0028, "event status");
    rd(status_report_pkg::CMD_READ_EVENT_STATUS, 16'h0000, "event reread");
    `CHECK("event summary cleared", 1'b0, ev_sum)
    $display("event test done");
  endtask : test_events

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs about 90 cycles; the ceiling leaves ample room
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    rst_b      = 1'b0;
    st         = '0;
    ev         = 8'h00;
    err_total  = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    test_reset();
    test_status_word();
    test_changes();
    test_events();
    tally_and_finish();
  end

endmodule : tb
`default_nettype wire
